// File: rtl/srb_special_regs.v
// special register space, status word, data pointer, system control and data ram
`timescale 1ns/1ps
`include "srb_consts.vh"

module srb_special_regs #(
  parameter CODE_BYTES = 8192,
  parameter CODE_AW    = 13
) (
  input  wire               clk,
  input  wire               nrst,
  input  wire [7:0]         mem_addr,
  input  wire               mem_direct,
  input  wire               mem_wr,
  input  wire [7:0]         mem_wdata,
  input  wire               mem_rd,
  output reg  [7:0]         mem_rdata,
  input  wire [7:0]         bit_addr,
  input  wire               bit_wr,
  input  wire               bit_wdata,
  input  wire               bit_rd,
  output reg                bit_rdata,
  input  wire [2:0]         work_reg_index,
  output reg  [7:0]         work_reg_rdata,
  input  wire               alu_add,
  input  wire [7:0]         alu_operand,
  input  wire               alu_use_carry,
  input  wire               dog_reset_cause,
  input  wire [CODE_AW-1:0] code_addr,
  input  wire               code_wr,
  input  wire [7:0]         code_wdata,
  output reg  [7:0]         code_rdata,
  output wire [15:0]        data_pointer,
  output wire [7:0]         active_bank_base,
  output wire [7:0]         program_status_word,
  output reg                address_latch_strobe
);

  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  reg  [7:0] sfr_mem [0:127];
  reg  [7:0] ram_mem [0:255];
  reg  [7:0] code_mem [0:CODE_BYTES-1];
  reg        dog_reset_flag;
  reg        reset_seen;
  reg  [2:0] ale_count;
  integer    i;

  // register locations as 8-bit words; the low seven bits index sfr_mem
  wire [7:0] acc_addr = `SRB_ACC;
  wire [7:0] psw_addr = `SRB_STATUS_WORD;
  wire [7:0] dpl_addr = `SRB_DATA_POINTER_LOW;
  wire [7:0] dph_addr = `SRB_DATA_POINTER_HIGH;
  wire [7:0] sys_addr = `SRB_SYS_CTL;
  wire [6:0] acc_idx  = acc_addr[6:0];
  wire [6:0] psw_idx  = psw_addr[6:0];
  wire [6:0] sys_idx  = sys_addr[6:0];
  wire [7:0] acc_byte;
  wire [7:0] psw_byte;
  wire       odd_bits_flag;
  wire [1:0] bank_sel;

  // --------------------------------------------------------------------------
  // writable mask per special register, zero for unmapped slots
  // --------------------------------------------------------------------------
  function [7:0] sfr_mask;
    input [7:0] addr;
    begin
      case (addr)
        `SRB_PORT0, `SRB_STACK_PTR, `SRB_DATA_POINTER_LOW, `SRB_DATA_POINTER_HIGH,
        `SRB_TIMER_CTL, `SRB_TIMER_MODE, `SRB_T0_LOW, `SRB_T1_LOW,
        `SRB_T0_HIGH, `SRB_T1_HIGH, `SRB_PORT1, `SRB_SERIAL_CTL,
        `SRB_SERIAL_BUF, `SRB_PORT2, `SRB_PORT3, `SRB_T2_CTL,
        `SRB_T2_RLD_LOW, `SRB_T2_RLD_HIGH, `SRB_T2_LOW, `SRB_T2_HIGH,
        `SRB_ACC, `SRB_MUL_DIV: sfr_mask = `SRB_MASK_FULL;
        `SRB_POWER_CTL:          sfr_mask = `SRB_MASK_POWER_CONTROL;
        `SRB_DOG_CTL:            sfr_mask = `SRB_MASK_DOG;
        `SRB_INT_ENABLE:         sfr_mask = `SRB_MASK_IE;
        `SRB_INT_PRIO:           sfr_mask = `SRB_MASK_IP;
        `SRB_SYS_CTL:            sfr_mask = `SRB_MASK_SYS;
        `SRB_STATUS_WORD:        sfr_mask = `SRB_MASK_PSW;
        default:                 sfr_mask = `SRB_MASK_NONE;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // status word composition
  // --------------------------------------------------------------------------
  assign acc_byte      = sfr_mem[acc_idx];
  assign odd_bits_flag = ^acc_byte;
  assign psw_byte      = {sfr_mem[psw_idx][7:2], 1'b0, odd_bits_flag};
  assign bank_sel      = {psw_byte[`SRB_PSW_RS1], psw_byte[`SRB_PSW_RS0]};
  assign active_bank_base    = {3'h0, bank_sel, 3'h0};
  assign program_status_word = psw_byte;
  assign data_pointer  = {sfr_mem[dph_addr[6:0]], sfr_mem[dpl_addr[6:0]]};

  // read view of one special register, dynamic bits merged in
  function [7:0] sfr_view;
    input [7:0] addr;
    input [7:0] stored;
    begin
      if (addr == `SRB_STATUS_WORD) begin
        sfr_view = psw_byte;
      end else if (addr == `SRB_SYS_CTL) begin
        sfr_view = {dog_reset_flag, 6'h00, stored[`SRB_SYS_LATCH_STROBE_INHIBIT]};
      end else begin
        sfr_view = stored & sfr_mask(addr);
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  wire       byte_is_sfr = mem_direct & mem_addr[7];
  wire [7:0] byte_mask   = sfr_mask(mem_addr);

  // bit space: 00h-7Fh in ram 20h-2Fh, 80h-FFh in registers on 8-byte rows
  wire       bit_is_sfr  = bit_addr[7];
  wire [7:0] bit_byte    = bit_is_sfr ? {bit_addr[7:3], 3'h0}
                                      : {`SRB_BIT_RAM_BASE, bit_addr[6:3]};
  wire [2:0] bit_pos     = bit_addr[2:0];
  wire [7:0] bit_mask    = sfr_mask(bit_byte);
  wire       bit_allowed = bit_mask[bit_pos];
  wire [7:0] bit_view    = sfr_view(bit_byte, sfr_mem[bit_byte[6:0]]);

  // --------------------------------------------------------------------------
  // add with carry; half carry and overflow from split sums
  // --------------------------------------------------------------------------
  wire       add_cin = alu_use_carry & psw_byte[`SRB_PSW_CY];
  wire [4:0] sum_lo  = {1'b0, acc_byte[3:0]} + {1'b0, alu_operand[3:0]} + {4'h0, add_cin};
  wire [3:0] sum_mid = {1'b0, acc_byte[6:4]} + {1'b0, alu_operand[6:4]} + {3'h0, sum_lo[4]};
  wire [1:0] sum_top = {1'b0, acc_byte[7]} + {1'b0, alu_operand[7]} + {1'b0, sum_mid[3]};
  wire [7:0] sum_val = {sum_top[0], sum_mid[2:0], sum_lo[3:0]};

  // --------------------------------------------------------------------------
  // special registers
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < 128; i = i + 1) begin
        sfr_mem[i] <= `SRB_ZERO_BYTE;
      end
      sfr_mem[7'h00] <= `SRB_PORT_RESET;
      sfr_mem[7'h10] <= `SRB_PORT_RESET;
      sfr_mem[7'h20] <= `SRB_PORT_RESET;
      sfr_mem[7'h30] <= `SRB_PORT_RESET;
    end else begin
      if (alu_add) begin
        sfr_mem[acc_idx] <= sum_val;
        sfr_mem[psw_idx][`SRB_PSW_CY] <= sum_top[1];
        sfr_mem[psw_idx][`SRB_PSW_AC] <= sum_lo[4];
        sfr_mem[psw_idx][`SRB_PSW_OV] <= sum_mid[3] ^ sum_top[1];
      end
      // bus write follows the add so software wins the same cycle
      if (mem_wr && byte_is_sfr) begin
        sfr_mem[mem_addr[6:0]] <= mem_wdata & byte_mask;
      end
      if (bit_wr && bit_is_sfr && bit_allowed) begin
        sfr_mem[bit_byte[6:0]][bit_pos] <= bit_wdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // watchdog cause caught on the first edge after reset release
  // --------------------------------------------------------------------------
  wire sys_wr_clear = (mem_wr && byte_is_sfr && mem_addr == `SRB_SYS_CTL &&
                       !mem_wdata[`SRB_SYS_DOG]) ||
                      (bit_wr && bit_is_sfr && bit_byte == `SRB_SYS_CTL &&
                       bit_pos == `SRB_SYS_DOG && !bit_wdata);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reset_seen     <= 1'b0;
      dog_reset_flag <= 1'b0;
    end else begin
      reset_seen <= 1'b1;
      if (!reset_seen && dog_reset_cause) begin
        dog_reset_flag <= 1'b1;
      end else if (sys_wr_clear) begin
        dog_reset_flag <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // data ram: indirect reaches all 256 bytes, direct only the low half
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (mem_wr && !byte_is_sfr) begin
      ram_mem[mem_addr] <= mem_wdata;
    end
    if (bit_wr && !bit_is_sfr) begin
      ram_mem[bit_byte][bit_pos] <= bit_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // registered read ports
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_rdata      <= `SRB_ZERO_BYTE;
      bit_rdata      <= 1'b0;
      work_reg_rdata <= `SRB_ZERO_BYTE;
    end else begin
      if (mem_rd) begin
        mem_rdata <= byte_is_sfr ? sfr_view(mem_addr, sfr_mem[mem_addr[6:0]])
                                 : ram_mem[mem_addr];
      end
      if (bit_rd) begin
        bit_rdata <= bit_is_sfr ? bit_view[bit_pos]
                                : ram_mem[bit_byte][bit_pos];
      end
      work_reg_rdata <= ram_mem[active_bank_base | {5'h00, work_reg_index}];
    end
  end

  // --------------------------------------------------------------------------
  // program memory, no reset: contents are loaded over the code write port
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (code_wr) begin
      code_mem[code_addr] <= code_wdata;
    end
    code_rdata <= code_mem[code_addr];
  end

  // --------------------------------------------------------------------------
  // latch strobe: clk divided by six, held low when inhibited to cut emi
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ale_count            <= `SRB_ALE_ZERO;
      address_latch_strobe <= 1'b0;
    end else begin
      ale_count <= (ale_count == `SRB_ALE_LAST) ? `SRB_ALE_ZERO : ale_count + 3'h1;
      address_latch_strobe <= !sfr_mem[sys_idx][`SRB_SYS_LATCH_STROBE_INHIBIT] &&
                              (ale_count < `SRB_ALE_HIGH);
    end
  end

endmodule // srb_special_regs

// File: rtl/srb_consts.vh
// constants for the special register bank: offsets, field positions, reset values, timing
`ifndef SRB_CONSTS_VH
`define SRB_CONSTS_VH

// ----------------------------------------------------------------------------
// special register offsets
// ----------------------------------------------------------------------------
`define SRB_SPACE_BASE   8'h80
`define SRB_PORT0        8'h80
`define SRB_STACK_PTR    8'h81
`define SRB_DATA_POINTER_LOW     8'h82
`define SRB_DATA_POINTER_HIGH    8'h83
`define SRB_RESERVED     8'h84
`define SRB_POWER_CTL    8'h87
`define SRB_TIMER_CTL    8'h88
`define SRB_TIMER_MODE   8'h89
`define SRB_T0_LOW       8'h8A
`define SRB_T1_LOW       8'h8B
`define SRB_T0_HIGH      8'h8C
`define SRB_T1_HIGH      8'h8D
`define SRB_PORT1        8'h90
`define SRB_SERIAL_CTL   8'h98
`define SRB_SERIAL_BUF   8'h99
`define SRB_DOG_CTL      8'h9F
`define SRB_PORT2        8'hA0
`define SRB_INT_ENABLE   8'hA8
`define SRB_PORT3        8'hB0
`define SRB_INT_PRIO     8'hB8
`define SRB_SYS_CTL      8'hBF
`define SRB_T2_CTL       8'hC8
`define SRB_T2_RLD_LOW   8'hCA
`define SRB_T2_RLD_HIGH  8'hCB
`define SRB_T2_LOW       8'hCC
`define SRB_T2_HIGH      8'hCD
`define SRB_STATUS_WORD  8'hD0
`define SRB_ACC          8'hE0
`define SRB_MUL_DIV      8'hF0

// ----------------------------------------------------------------------------
// writable bit masks (zero bits are ignored on write and read as zero, except status word parity and the system control watchdog flag)
// ----------------------------------------------------------------------------
`define SRB_MASK_FULL    8'hFF
`define SRB_MASK_NONE    8'h00
`define SRB_MASK_POWER_CONTROL    8'h8F
`define SRB_MASK_DOG     8'hA7
`define SRB_MASK_IE      8'hBF
`define SRB_MASK_IP      8'h3F
`define SRB_MASK_SYS     8'h01
`define SRB_MASK_PSW     8'hFC

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SRB_PSW_CY       7
`define SRB_PSW_AC       6
`define SRB_PSW_F0       5
`define SRB_PSW_RS1      4
`define SRB_PSW_RS0      3
`define SRB_PSW_OV       2
`define SRB_PSW_P        0
`define SRB_SYS_DOG      7
`define SRB_SYS_LATCH_STROBE_INHIBIT     0

// ----------------------------------------------------------------------------
// memory layout, reset values, timing
// ----------------------------------------------------------------------------
`define SRB_BIT_RAM_BASE 4'h2
`define SRB_ZERO_BYTE    8'h00
`define SRB_PORT_RESET   8'hFF
`define SRB_ALE_LAST     3'h5
`define SRB_ALE_HIGH     3'h3
`define SRB_ALE_ZERO     3'h0

`endif

// File: verification/srb_properties.sv
// assertion checker for the special register bank ports
`timescale 1ns/1ps
module srb_checker (
  input logic        clk,
  input logic        nrst,
  input logic [7:0]  mem_addr,
  input logic        mem_direct,
  input logic        mem_wr,
  input logic [7:0]  mem_wdata,
  input logic        mem_rd,
  input logic [7:0]  mem_rdata,
  input logic        bit_wr,
  input logic        alu_add,
  input logic [15:0] data_pointer,
  input logic [7:0]  active_bank_base,
  input logic [7:0]  program_status_word,
  input logic        address_latch_strobe
);
  // ----------------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_data_pointer_low: assert property (
    mem_wr && mem_direct && mem_addr == 8'h82 |=> data_pointer[7:0] == $past(mem_wdata))
    else $error("data pointer low byte not updated");
  chk_data_pointer_high: assert property (
    mem_wr && mem_direct && mem_addr == 8'h83 |=> data_pointer[15:8] == $past(mem_wdata))
    else $error("data pointer high byte not updated");
  chk_bank_base: assert property (
    active_bank_base == {3'h0, program_status_word[4:3], 3'h0})
    else $error("bank base does not follow select bits");
  chk_psw_write: assert property (
    mem_wr && mem_direct && mem_addr == 8'hD0 && !alu_add && !bit_wr
    |=> program_status_word[7:2] == $past(mem_wdata[7:2]))
    else $error("status word write lost");
  chk_parity_acc: assert property (
    mem_wr && mem_direct && mem_addr == 8'hE0 && !bit_wr
    |=> program_status_word[0] == ^$past(mem_wdata))
    else $error("parity flag wrong after accumulator write");
  chk_unused_bit: assert property (
    program_status_word[1] == 1'b0)
    else $error("unused status bit set");
  chk_rsvd_read: assert property (
    mem_rd && mem_direct && mem_addr == 8'h84 |=> mem_rdata == 8'h00)
    else $error("reserved location not zero");
  chk_strobe_width: assert property (
    address_latch_strobe [*3] |=> !address_latch_strobe)
    else $error("strobe high too long");
  chk_strobe_gap: assert property (
    $rose(address_latch_strobe) |-> !$past(address_latch_strobe, 2) && !$past(address_latch_strobe, 3))
    else $error("strobe low phase too short");
  chk_strobe_inhibit: assert property (
    (mem_wr && mem_direct && mem_addr == 8'hBF && mem_wdata[0])
    ##1 !(mem_wr && mem_direct && mem_addr == 8'hBF) |=> !address_latch_strobe)
    else $error("strobe not inhibited");
endmodule // srb_checker

// File: verification/testbench.sv
// self-checking bench for the special register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic        clk = 0, nrst = 0, mem_direct = 1, mem_wr = 0, mem_rd = 0;
  logic        bit_wr = 0, bit_wdata = 0, bit_rd = 0, alu_add = 0, alu_use_carry = 0;
  logic        dog_reset_cause = 0, code_wr = 0, bit_rdata, address_latch_strobe;
  logic [7:0]  mem_addr = 0, mem_wdata = 0, bit_addr = 0, alu_operand = 0, code_wdata = 0;
  logic [7:0]  mem_rdata, work_reg_rdata, code_rdata, active_bank_base, program_status_word;
  logic [2:0]  work_reg_index = 5;
  logic [12:0] code_addr = 0;
  logic [15:0] data_pointer;
  int          errors = 0, check_count = 0, cycles = 0, i, n;
  srb_special_regs i_srb_special_regs (.clk(clk), .nrst(nrst), .mem_addr(mem_addr),
    .mem_direct(mem_direct), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_wdata(bit_wdata),
    .bit_rd(bit_rd), .bit_rdata(bit_rdata), .work_reg_index(work_reg_index),
    .work_reg_rdata(work_reg_rdata), .alu_add(alu_add), .alu_operand(alu_operand),
    .alu_use_carry(alu_use_carry), .dog_reset_cause(dog_reset_cause),
    .code_addr(code_addr), .code_wr(code_wr), .code_wdata(code_wdata),
    .code_rdata(code_rdata), .data_pointer(data_pointer),
    .active_bank_base(active_bank_base), .program_status_word(program_status_word),
    .address_latch_strobe(address_latch_strobe));
  always #2 clk = ~clk;
  // ----------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, d, input logic dir = 1);
    @(posedge clk);
    mem_addr <= a;
    mem_wdata <= d;
    mem_direct <= dir;
    mem_wr <= 1'b1;
    @(posedge clk);
    mem_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e, input logic dir = 1);
    @(posedge clk);
    mem_addr <= a;
    mem_direct <= dir;
    mem_rd <= 1'b1;
    @(posedge clk);
    mem_rd <= 1'b0;
    #1;
    `CHK("mem_rdata", e, mem_rdata)
  endtask
  task automatic bwr(input logic [7:0] a, input logic d, rdb);
    @(posedge clk);
    bit_addr <= a;
    bit_wdata <= d;
    bit_wr <= !rdb;
    bit_rd <= rdb;
    @(posedge clk);
    bit_wr <= 1'b0;
    bit_rd <= 1'b0;
    #1;
  endtask
  // flags compared as {carry, half carry, overflow, parity}
  task automatic alu(input logic [7:0] a, b, input logic c, input logic [3:0] f);
    wr(8'hE0, a);
    @(posedge clk);
    alu_operand <= b;
    alu_use_carry <= c;
    alu_add <= 1'b1;
    @(posedge clk);
    alu_add <= 1'b0;
    #1;
    `CHK("flags", f, {program_status_word[7:6], program_status_word[2], program_status_word[0]})
    rd(8'hE0, a + b + c);
  endtask
  task automatic strobe_count(output int cnt);
    cnt = 0;
    repeat (12) begin
      @(posedge clk);
      #1;
      cnt += (address_latch_strobe === 1'b1);
    end
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_space();
    rd(8'h80, 8'hFF);
    rd(8'h87, 8'h00);
    rd(8'hBF, 8'h00);
    wr(8'h80, 8'h5A);
    wr(8'h80, 8'hA5, 0);
    rd(8'h80, 8'h5A);
    rd(8'h80, 8'hA5, 0);
    wr(8'h84, 8'hFF);
    rd(8'h84, 8'h00);
    wr(8'h87, 8'hFF);
    rd(8'h87, 8'h8F);
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    #1;
    `CHK("data_pointer", 16'h1234, data_pointer)
    rd(8'h83, 8'h12);
  endtask
  task automatic t_banks();
    for (i = 0; i < 4; i++) begin
      wr(i * 8 + 5, 8'h60 + i, 0);
      wr(8'hD0, i << 3);
      repeat (2) @(posedge clk);
      #1;
      `CHK("work_reg_rdata", 8'h60 + i, work_reg_rdata)
      `CHK("active_bank_base", i * 8, active_bank_base)
    end
  endtask
  task automatic t_status();
    wr(8'hE0, 8'h00);
    wr(8'hD0, 8'h00);
    for (i = 1; i < 8; i++) begin
      bwr(8'hD0 + i, 1'b1, 1'b0);
      `CHK("psw_bit", i != 1, program_status_word[i])
    end
    bwr(8'hD7, 1'b0, 1'b1);
    `CHK("bit_rdata", 1'b1, bit_rdata)
    rd(8'hD0, 8'hFC);
    wr(8'h21, 8'h00, 0);
    bwr(8'h0B, 1'b1, 1'b0);
    rd(8'h21, 8'h08, 0);
    alu(8'h7F, 8'h01, 0, 4'b0111);
    alu(8'hFF, 8'h01, 0, 4'b1100);
    alu(8'h0A, 8'h05, 1, 4'b0101);
    alu(8'h80, 8'h80, 0, 4'b1010);
    for (i = 0; i < 8; i++) begin
      wr(8'hE0, 8'hFF >> i);
      #1;
      `CHK("parity", 1'((8 - i) % 2), program_status_word[0])
    end
  endtask
  task automatic t_sysctl();
    @(posedge clk);
    nrst <= 1'b0;
    dog_reset_cause <= 1'b1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    dog_reset_cause <= 1'b0;
    rd(8'hBF, 8'h80);
    wr(8'hBF, 8'hFF);
    rd(8'hBF, 8'h81);
    wr(8'hBF, 8'h00);
    rd(8'hBF, 8'h00);
    wr(8'hBF, 8'h01);
    repeat (2) @(posedge clk);
    strobe_count(n);
    `CHK("strobe_inhibited", 0, n)
    wr(8'hBF, 8'h00);
    repeat (2) @(posedge clk);
    strobe_count(n);
    `CHK("strobe_free", 6, n)
  endtask
  task automatic t_code();
    @(posedge clk);
    code_addr <= 13'h1FFF;
    code_wdata <= 8'h5C;
    code_wr <= 1'b1;
    @(posedge clk);
    code_wr <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("code_rdata", 8'h5C, code_rdata)
  endtask
  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ceiling well above the roughly 170 cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_space();
    t_banks();
    t_status();
    t_code();
    t_sysctl();
    wrap_up();
  end
endmodule // testbench
bind srb_special_regs srb_checker i_srb_checker (.clk(clk), .nrst(nrst), .mem_addr(mem_addr),
  .mem_direct(mem_direct), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
  .mem_rdata(mem_rdata), .bit_wr(bit_wr), .alu_add(alu_add), .data_pointer(data_pointer),
  .active_bank_base(active_bank_base), .program_status_word(program_status_word),
  .address_latch_strobe(address_latch_strobe));
